// file: csx_pkg.sv
// Package of constants and types for the extended control and status registers
`default_nettype none
package csx_pkg;

    // ------------------------------------------------------------
    // Access spaces
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSX_SP_BASE,
        CSX_SP_EXT,
        CSX_SP_CIND
    } csx_space_t;

    // ------------------------------------------------------------
    // Offsets and indices
    // ------------------------------------------------------------
    localparam logic [4:0] CSX_BASE_JOY = 5'h00;
    localparam logic [4:0] CSX_BASE_CMP = 5'h01;
    localparam logic [4:0] CSX_BASE_BPD = 5'h02;
    localparam logic [4:0] CSX_BASE_GST = 5'h07;
    localparam logic [4:0] CSX_EXT_JOY  = 5'h1A;
    localparam logic [4:0] CSX_EXT_CMP  = 5'h1B;
    localparam logic [4:0] CSX_EXT_BPD  = 5'h1C;
    localparam logic [4:0] CSX_EXT_PM   = 5'h1D;
    localparam logic [4:0] CSX_EXT_GST  = 5'h1E;
    localparam logic [4:0] CSX_EXT_RSV  = 5'h1F;
    localparam logic [4:0] CSX_CIND_PM  = 5'h09;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int CSX_JOY_CRYS  = 3;
    localparam int CSX_JOY_CTXEN = 5;
    localparam int CSX_CMP_CLK   = 0;
    localparam int CSX_CMP_DOUT  = 1;
    localparam int CSX_CMP_EN    = 2;
    localparam int CSX_CMP_POL   = 7;
    localparam int CSX_PM_SERIAL = 0;
    localparam int CSX_PM_SYNTH  = 1;
    localparam int CSX_PM_MIX    = 2;
    localparam int CSX_PM_RESET  = 7;
    localparam logic [7:0] CSX_JOY_MASK  = 8'h2B;
    localparam logic [7:0] CSX_JOY_XMASK = 8'h23;
    localparam logic [7:0] CSX_CMP_MASK  = 8'h87;
    localparam logic [7:0] CSX_PM_MASK   = 8'h87;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CSX_JOY_RST = 8'h01;
    localparam logic [7:0] CSX_CMP_RST = 8'h80;
    localparam logic [7:0] CSX_BPD_RST = 8'h00;
    localparam logic [7:0] CSX_PM_RST  = 8'h00;
    localparam logic [7:0] CSX_GST_RST = 8'h80;

endpackage
`default_nettype wire

// file: csx_sync_if.sv
// Interface carrying raw pin levels to the synchroniser and synced levels back
`timescale 1ns/1ps
`default_nettype none
interface csx_sync_if #(parameter int W = 3);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src  (output raw, input  sync);
    modport sink (input  raw, output sync);
endinterface // csx_sync_if
`default_nettype wire

// file: csx_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module csx_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Pin levels
    csx_sync_if.sink  sif
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } csx_sync_st_t;

    csx_sync_st_t q;
    csx_sync_st_t d;

    // First stage feeds only the second stage
    always_comb begin
        d    = q;
        d.s1 = sif.raw;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.sync = q.s2;
endmodule // csx_sync
`default_nettype wire

// file: csx_regs.sv
// Extended control and status register bank with memory port and status
`timescale 1ns/1ps
`default_nettype none
module csx_regs (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // Host register access
    input  wire csx_pkg::csx_space_t host_space,
    input  wire logic [4:0]          host_idx,
    input  wire logic                host_wr,
    input  wire logic                host_rd,
    input  wire logic [7:0]          host_wdata,
    output logic [7:0]               host_rdata,
    output logic                     host_rvalid,
    // Configuration memory pins
    output logic                     scl_o,
    output logic                     scl_oe,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe,
    // Optical drive interrupt pin
    input  wire logic                optical_irq_pin,
    output logic                     optical_irq_active,
    input  wire logic                hwcfg_load,
    input  wire logic                hwcfg_optical_pol,
    // Serial video port
    input  wire logic                serial_video_input,
    // Internal events and levels
    input  wire logic                ctx_switch_event,
    input  wire logic                context_is_codec,
    input  wire logic                vol_button_press,
    input  wire logic                volume_button_irq_enable,
    input  wire logic                bus_error,
    input  wire logic                midi_port_irq_pending,
    input  wire logic                codec_irq_pending,
    input  wire logic                legacy_game_irq_pending,
    // Control outputs
    output logic                     codec_access_block,
    output logic                     crystal_select,
    output logic [1:0]               joystick_rate,
    output logic                     ctrl_irq,
    output logic [7:0]               block_power_down,
    output logic                     serial_ports_power_down,
    output logic                     second_dac_power_down,
    output logic                     analog_mixer_power_down,
    output logic                     bus_reset_drive,
    output logic                     processor_reset
);
    import csx_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] joy;
        logic       kill;
        logic [7:0] cmp;
        logic [7:0] bpd;
        logic [7:0] pm;
        logic       vol_irq;
        logic       watchdog;
        logic       ctl_irq;
        logic       ctx;
        logic [7:0] rdata;
        logic       rvalid;
        logic       soft_rst;
        logic       proc_rst;
    } csx_state_t;

    localparam csx_state_t CSX_ST_RST = '{
        joy:      CSX_JOY_RST,
        kill:     1'b0,
        cmp:      CSX_CMP_RST,
        bpd:      CSX_BPD_RST,
        pm:       CSX_PM_RST,
        vol_irq:  CSX_GST_RST[1],
        watchdog: CSX_GST_RST[2],
        ctl_irq:  CSX_GST_RST[6],
        ctx:      CSX_GST_RST[7],
        rdata:    8'h00,
        rvalid:   1'b0,
        soft_rst: 1'b0,
        proc_rst: 1'b0
    };

    csx_state_t q;
    csx_state_t d;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    csx_sync_if #(.W(3)) sif ();

    logic sda_s;
    logic opt_s;
    logic video_s;

    assign sif.raw = {serial_video_input, optical_irq_pin, sda_i};
    assign sda_s   = sif.sync[0];
    assign opt_s   = sif.sync[1];
    assign video_s = sif.sync[2];

    csx_sync #(.W(3)) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .sif     (sif.sink)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic sp_b;
    logic sp_x;
    logic sp_c;
    logic hit_joy_b;
    logic hit_joy_x;
    logic hit_cmp;
    logic hit_bpd;
    logic hit_pm;
    logic hit_gst;
    logic rd_gst;
    logic wr_pm;
    logic [7:0] gstat;

    assign sp_b      = (host_space == CSX_SP_BASE);
    assign sp_x      = (host_space == CSX_SP_EXT);
    assign sp_c      = (host_space == CSX_SP_CIND);
    assign hit_joy_b = sp_b && (host_idx == CSX_BASE_JOY);
    assign hit_joy_x = sp_x && (host_idx == CSX_EXT_JOY);
    assign hit_cmp   = (sp_b && (host_idx == CSX_BASE_CMP))
                    || (sp_x && (host_idx == CSX_EXT_CMP));
    assign hit_bpd   = (sp_b && (host_idx == CSX_BASE_BPD))
                    || (sp_x && (host_idx == CSX_EXT_BPD));
    assign hit_pm    = (sp_c && (host_idx == CSX_CIND_PM))
                    || (sp_x && (host_idx == CSX_EXT_PM));
    assign hit_gst   = (sp_b && (host_idx == CSX_BASE_GST))
                    || (sp_x && (host_idx == CSX_EXT_GST));
    assign rd_gst    = host_rd && hit_gst;
    assign wr_pm     = host_wr && hit_pm;

    // Pending and context view
    assign gstat = {q.ctx,
                    q.ctl_irq,
                    legacy_game_irq_pending,
                    codec_irq_pending,
                    midi_port_irq_pending,
                    q.watchdog,
                    q.vol_irq,
                    video_s};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rmux;
        rmux       = 8'h00;
        d          = q;
        d.rvalid   = 1'b0;
        d.soft_rst = 1'b0;
        d.proc_rst = 1'b0;
        d.ctx      = context_is_codec;

        // Writes; status and reserved spaces take none
        if (host_wr && hit_joy_b) begin
            d.joy = host_wdata & CSX_JOY_MASK;
        end
        if (host_wr && hit_joy_x) begin
            d.joy  = (host_wdata & CSX_JOY_XMASK) | (q.joy & ~CSX_JOY_XMASK);
            d.kill = host_wdata[CSX_JOY_CRYS];
        end
        if (host_wr && hit_cmp) begin
            d.cmp = host_wdata & CSX_CMP_MASK;
        end else if (hwcfg_load) begin
            d.cmp[CSX_CMP_POL] = hwcfg_optical_pol;
        end
        if (host_wr && hit_bpd) begin
            d.bpd = host_wdata;
        end
        if (wr_pm) begin
            d.pm = host_wdata & CSX_PM_MASK;
            if (q.pm[CSX_PM_RESET] && !host_wdata[CSX_PM_RESET]) begin
                d.soft_rst = 1'b1;
            end
        end

        // Reads; unmapped and reserved read as zero
        if (hit_joy_b) begin
            rmux = q.joy;
        end else if (hit_joy_x) begin
            rmux = {q.joy[7:4], q.kill, q.joy[2:0]};
        end else if (hit_cmp) begin
            rmux = {q.cmp[7:3], sda_s, q.cmp[1:0]};
        end else if (hit_bpd) begin
            rmux = q.bpd;
        end else if (hit_pm) begin
            rmux = q.pm;
        end else if (hit_gst) begin
            rmux = gstat;
        end
        if (host_rd) begin
            d.rdata  = rmux;
            d.rvalid = 1'b1;
        end

        // Clear on read first, so a same-cycle event wins
        if (rd_gst) begin
            d.vol_irq = 1'b0;
            d.ctl_irq = 1'b0;
        end
        if (vol_button_press && volume_button_irq_enable) begin
            d.vol_irq = 1'b1;
        end
        if (ctx_switch_event && q.joy[CSX_JOY_CTXEN]) begin
            d.ctl_irq = 1'b1;
        end
        if (bus_error) begin
            d.watchdog = 1'b1;
            d.proc_rst = 1'b1;
        end
    end

    // Soft reset returns everything, itself included, to power-up values
    always_ff @(posedge ref_clk) begin
        if (!rstn || q.soft_rst) begin
            q <= CSX_ST_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign host_rdata         = q.rdata;
    assign host_rvalid        = q.rvalid;
    assign scl_oe             = q.cmp[CSX_CMP_EN];
    assign scl_o              = q.cmp[CSX_CMP_CLK];
    assign sda_o              = 1'b0;
    assign sda_oe             = q.cmp[CSX_CMP_EN] && !q.cmp[CSX_CMP_DOUT];
    assign optical_irq_active = (opt_s == q.cmp[CSX_CMP_POL]);
    assign codec_access_block = q.kill;
    assign crystal_select     = q.joy[CSX_JOY_CRYS];
    assign joystick_rate      = q.joy[1:0];
    assign ctrl_irq           = q.ctl_irq;
    assign block_power_down   = q.bpd;
    assign serial_ports_power_down = q.pm[CSX_PM_SERIAL];
    assign second_dac_power_down   = q.pm[CSX_PM_SYNTH];
    assign analog_mixer_power_down = q.pm[CSX_PM_MIX];
    assign bus_reset_drive    = q.soft_rst;
    assign processor_reset    = q.proc_rst;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic ok;
    assign ok = !bus_reset_drive;

    property p_kill;
        (host_wr && hit_joy_x && ok) |=> (codec_access_block == $past(host_wdata[3]));
    endproperty
    a_kill: assert property (p_kill) else $error("kill bit not applied");

    property p_ctx_irq;
        (ctx_switch_event && q.joy[CSX_JOY_CTXEN] && ok) |=> ctrl_irq;
    endproperty
    a_ctx_irq: assert property (p_ctx_irq) else $error("ctx irq missing");

    property p_ctx_quiet;
        (!ctrl_irq && !(ctx_switch_event && q.joy[CSX_JOY_CTXEN])) |=> !ctrl_irq;
    endproperty
    a_ctx_quiet: assert property (p_ctx_quiet) else $error("ctx irq spurious");

    property p_mirror;
        (host_wr && sp_x && host_idx == CSX_EXT_CMP && ok)
        ##1 (host_rd && !host_wr && sp_b && host_idx == CSX_BASE_CMP && ok)
        |=> (host_rdata[1:0] == $past(host_wdata[1:0], 2));
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror mismatch");

    property p_pins;
        (host_wr && hit_cmp && ok && host_wdata[2])
        |=> (scl_oe && scl_o == $past(host_wdata[0]) && sda_oe == !$past(host_wdata[1]));
    endproperty
    a_pins: assert property (p_pins) else $error("pin drive wrong");

    property p_off;
        (host_wr && hit_cmp && ok && !host_wdata[2]) |=> (!scl_oe && !sda_oe);
    endproperty
    a_off: assert property (p_off) else $error("port not released");

    property p_din;
        (host_rd && hit_cmp && ok) |=> (host_rdata[2] == $past(sda_i, 3));
    endproperty
    a_din: assert property (p_din) else $error("sda readback wrong");

    property p_opt;
        optical_irq_active == ($past(optical_irq_pin, 2) == q.cmp[CSX_CMP_POL]);
    endproperty
    a_opt: assert property (p_opt) else $error("optical polarity wrong");

    property p_rst;
        $rose(rstn) |-> (q.cmp[7] && q.cmp[2:0] == 3'h0 && block_power_down == 8'h00
                         && q.pm == 8'h00 && q.ctx);
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");

    property p_soft;
        (wr_pm && q.pm[7] && !host_wdata[7] && ok)
        |=> bus_reset_drive ##1 (block_power_down == 8'h00 && q.pm == 8'h00 && !bus_reset_drive);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset missing");

    property p_stat;
        (host_rd && hit_gst && ok) |=> (host_rdata[5:3] == $past({legacy_game_irq_pending,
            codec_irq_pending, midi_port_irq_pending}) && host_rdata[7] == $past(q.ctx)
            && host_rdata[0] == $past(serial_video_input, 3));
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");

    property p_vol_clr;
        (rd_gst && !vol_button_press && ok) |=> !q.vol_irq;
    endproperty
    a_vol_clr: assert property (p_vol_clr) else $error("volume status not cleared");

    property p_vol_set;
        (vol_button_press && volume_button_irq_enable && ok) |=> q.vol_irq;
    endproperty
    a_vol_set: assert property (p_vol_set) else $error("volume status not set");

    property p_watchdog;
        (bus_error && ok) |=> (processor_reset && q.watchdog);
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog missing");

    property p_gst_ro;
        (host_wr && hit_gst && !host_rd && !vol_button_press && !ctx_switch_event && ok)
        |=> (q.vol_irq == $past(q.vol_irq) && q.ctl_irq == $past(q.ctl_irq));
    endproperty
    a_gst_ro: assert property (p_gst_ro) else $error("status changed by write");

    property p_rsvd;
        (host_rd && sp_x && host_idx == CSX_EXT_RSV) |=> (host_rdata == 8'h00);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero");

    c_soft:  cover property (wr_pm && q.pm[7] && !host_wdata[7]);
    c_ctx:   cover property ($rose(ctrl_irq));
    c_vol:   cover property (q.vol_irq ##1 rd_gst ##1 !q.vol_irq);
    c_eerd:  cover property (scl_oe && !sda_oe && host_rd && hit_cmp);
endmodule // csx_regs
`default_nettype wire

// file: csx_eeprom_model.sv
// Behavioural serial configuration memory seen on the two-wire pins
`timescale 1ns/1ps
`default_nettype none
module csx_eeprom_model (
    // Pins from the device
    input  wire logic scl_o,
    input  wire logic scl_oe,
    input  wire logic sda_o,
    input  wire logic sda_oe,
    // Bench controls
    input  wire logic force_low,
    input  wire logic ack_req,
    // Resolved data line
    output logic      sda_line
);
    logic scl_line;
    logic ack_q = 1'b0;
    // Pull-up keeps the clock high when the device lets go
    assign scl_line = scl_oe ? scl_o : 1'b1;
    // Slow answer: data only turns round after a falling clock
    always @(negedge scl_line) ack_q <= ack_req;
    // Open drain with pull-up, so a released line reads high
    assign sda_line = !((sda_oe && !sda_o) || force_low || ack_q);
endmodule // csx_eeprom_model
`default_nettype wire

// file: control_status_ext_regs_test.sv
// Self-checking testbench for the extended control and status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module control_status_ext_regs_test;
    import csx_pkg::*;
    logic       ref_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rvalid;
    csx_space_t sp = CSX_SP_BASE;
    logic [4:0] idx = 5'h00;
    logic [7:0] wdata = 8'h00, rdata, bpd;
    logic [3:0] ev = 4'h0;
    logic       scl_o, scl_oe, sda_o, sda_oe, sda_line, opt_act, kill, crys, ctrl_irq;
    logic       opt_pin = 1'b0, hw_pol = 1'b1, video = 1'b0, ctx_codec = 1'b1, vol_en = 1'b0;
    logic       midi = 1'b0, codec = 1'b0, legacy = 1'b0, force_low = 1'b1, ack_req = 1'b0;
    logic       serial_ports_power_down_pd, second_dac_power_down_pd, mix_pd, rst_drv, proc_rst;
    logic [1:0] rate;
    int         err_total = 0, checks_done = 0;

    always #2.5 ref_clk = ~ref_clk;

    csx_regs csx_regs_inst (.ref_clk(ref_clk), .rstn(rstn), .host_space(sp), .host_idx(idx),
        .host_wr(wr), .host_rd(rd), .host_wdata(wdata), .host_rdata(rdata),
        .host_rvalid(rvalid), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .optical_irq_pin(opt_pin),
        .optical_irq_active(opt_act), .hwcfg_load(ev[3]), .hwcfg_optical_pol(hw_pol),
        .serial_video_input(video), .ctx_switch_event(ev[0]), .context_is_codec(ctx_codec),
        .vol_button_press(ev[1]), .volume_button_irq_enable(vol_en), .bus_error(ev[2]),
        .midi_port_irq_pending(midi), .codec_irq_pending(codec),
        .legacy_game_irq_pending(legacy), .codec_access_block(kill), .crystal_select(crys),
        .joystick_rate(rate), .ctrl_irq(ctrl_irq), .block_power_down(bpd),
        .serial_ports_power_down(serial_ports_power_down_pd), .second_dac_power_down(second_dac_power_down_pd),
        .analog_mixer_power_down(mix_pd), .bus_reset_drive(rst_drv),
        .processor_reset(proc_rst));

    csx_eeprom_model csx_eeprom_model_inst (.scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
        .sda_oe(sda_oe), .force_low(force_low), .ack_req(ack_req), .sda_line(sda_line));

    // ------------------------------------------------------------
    // Bus and event helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr_reg(input csx_space_t s, input logic [4:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        sp <= s;
        idx <= i;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input csx_space_t s, input logic [4:0] i, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge ref_clk);
        sp <= s;
        idx <= i;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        while (rvalid !== 1'b1 && n < 4) begin
            cyc(1);
            n++;
        end
        if (n == 4) begin
            err_total++;
            conclude();
        end else begin
            `CHK(rdata, e)
        end
    endtask

    // Write by extended index, read by base offset on the very next cycle
    task automatic wr_then_rd(input logic [7:0] d, input logic [7:0] e);
        @(posedge ref_clk);
        sp <= CSX_SP_EXT;
        idx <= CSX_EXT_CMP;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        sp <= CSX_SP_BASE;
        idx <= CSX_BASE_CMP;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        `CHK({rvalid, rdata}, {1'b1, e})
    endtask

    // One-cycle pulse: 0 context switch, 1 volume, 2 bus error, 3 config load
    task automatic pulse(input int k);
        @(posedge ref_clk);
        ev <= 4'h1 << k;
        @(posedge ref_clk);
        ev <= 4'h0;
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        rd_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h80);
        rd_reg(CSX_SP_BASE, CSX_BASE_BPD, 8'h00);
        rd_reg(CSX_SP_CIND, CSX_CIND_PM, 8'h00);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h80);
        `CHK({scl_oe, sda_oe, rate}, 4'h1)
    endtask

    task automatic t_eeprom_port();
        @(posedge ref_clk);
        force_low <= 1'b0;
        wr_reg(CSX_SP_EXT, CSX_EXT_CMP, 8'h05);
        `CHK({scl_oe, scl_o, sda_oe, sda_o}, 4'hE)
        cyc(3);
        rd_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h01);
        wr_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h06);
        `CHK({scl_oe, scl_o, sda_oe}, 3'b100)
        cyc(3);
        rd_reg(CSX_SP_EXT, CSX_EXT_CMP, 8'h06);
        @(posedge ref_clk);
        ack_req <= 1'b1;
        wr_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h07);
        wr_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h06);
        cyc(3);
        rd_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h02);
        @(posedge ref_clk);
        ack_req <= 1'b0;
        wr_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h07);
        wr_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h06);
        wr_reg(CSX_SP_EXT, CSX_EXT_CMP, 8'h00);
        `CHK({scl_oe, sda_oe}, 2'b00)
        cyc(3);
        rd_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h04);
        wr_then_rd(8'h03, 8'h07);
        wr_reg(CSX_SP_EXT, CSX_EXT_CMP, 8'h00);
    endtask

    task automatic t_polarity();
        cyc(3);
        `CHK(opt_act, 1'b1)
        @(posedge ref_clk);
        opt_pin <= 1'b1;
        cyc(3);
        `CHK(opt_act, 1'b0)
        pulse(3);
        `CHK(opt_act, 1'b1)
        rd_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h84);
    endtask

    task automatic t_joystick_kill();
        wr_reg(CSX_SP_EXT, CSX_EXT_JOY, 8'h08);
        `CHK({kill, crys}, 2'b10)
        wr_reg(CSX_SP_BASE, CSX_BASE_JOY, 8'h0B);
        `CHK({kill, crys, rate}, 4'hF)
        rd_reg(CSX_SP_EXT, CSX_EXT_JOY, 8'h0B);
        wr_reg(CSX_SP_EXT, CSX_EXT_JOY, 8'h00);
        `CHK({kill, crys, rate}, 4'h4)
        rd_reg(CSX_SP_BASE, CSX_BASE_JOY, 8'h08);
    endtask

    task automatic t_status();
        @(posedge ref_clk);
        {midi, legacy, video, ctx_codec} <= 4'b1110;
        cyc(3);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h29);
        @(posedge ref_clk);
        {midi, codec, legacy, video, ctx_codec} <= 5'b01001;
        cyc(3);
        rd_reg(CSX_SP_EXT, CSX_EXT_GST, 8'h90);
        wr_reg(CSX_SP_BASE, CSX_BASE_GST, 8'hFF);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h90);
        pulse(0);
        `CHK(ctrl_irq, 1'b0)
        wr_reg(CSX_SP_BASE, CSX_BASE_JOY, 8'h20);
        pulse(0);
        `CHK(ctrl_irq, 1'b1)
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'hD0);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h90);
        pulse(1);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h90);
        @(posedge ref_clk);
        vol_en <= 1'b1;
        pulse(1);
        rd_reg(CSX_SP_EXT, CSX_EXT_GST, 8'h92);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h90);
        pulse(2);
        `CHK(proc_rst, 1'b1)
        cyc(1);
        `CHK(proc_rst, 1'b0)
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h94);
    endtask

    task automatic t_power_reset();
        wr_reg(CSX_SP_CIND, CSX_CIND_PM, 8'h07);
        `CHK({mix_pd, second_dac_power_down_pd, serial_ports_power_down_pd}, 3'b111)
        wr_reg(CSX_SP_EXT, CSX_EXT_PM, 8'h7A);
        `CHK({mix_pd, second_dac_power_down_pd, serial_ports_power_down_pd}, 3'b010)
        rd_reg(CSX_SP_CIND, CSX_CIND_PM, 8'h02);
        wr_reg(CSX_SP_BASE, CSX_BASE_BPD, 8'hA5);
        rd_reg(CSX_SP_EXT, CSX_EXT_BPD, 8'hA5);
        wr_reg(CSX_SP_EXT, CSX_EXT_RSV, 8'hFF);
        rd_reg(CSX_SP_EXT, CSX_EXT_RSV, 8'h00);
        wr_reg(CSX_SP_EXT, CSX_EXT_PM, 8'h80);
        wr_reg(CSX_SP_EXT, CSX_EXT_PM, 8'h00);
        `CHK(rst_drv, 1'b1)
        cyc(1);
        `CHK({rst_drv, bpd}, 9'h000)
        @(posedge ref_clk);
        force_low <= 1'b1;
        codec <= 1'b0;
        cyc(3);
        rd_reg(CSX_SP_BASE, CSX_BASE_CMP, 8'h80);
        rd_reg(CSX_SP_BASE, CSX_BASE_GST, 8'h80);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset_values();
        t_eeprom_port();
        t_polarity();
        t_joystick_kill();
        t_status();
        t_power_reset();
        conclude();
    end
endmodule // control_status_ext_regs_test
`default_nettype wire
